// ==== hdl/mic_mute_defs.svh ====
// What this block does
// - Two mixers, voice and comfort noise, feed one multiplexer to one output.
// - Each mixer takes four selectable sources, each with its own volume.
// - Source and volume registers of both mixers sit at 0660h to 066Fh.
// - Other functions pick this stage output with source code 0Ch.
// - Mixers and multiplexer run at the rate set by the stage rate setting.
// - Control bit 6 enables the stage output; resets to 0.
// - Control bit 7 picks voice (0) or comfort noise (1); resets to 0.
// - Enabling a path is refused when clock cycles per sample are short.
// - A refused enable leaves all active paths running untouched.
// - A refused enable raises an under-clock error to interrupt and pin.
// - Status bits read back which mixer paths really got enabled.
// - Source code 00h feeds silence into that mixer input.
`ifndef MIC_MUTE_DEFS_SVH
`define MIC_MUTE_DEFS_SVH

// ****************************************************************
// Register map (word addresses)
// ****************************************************************
`define ADDR_W          12
`define DATA_W          16
`define ADDR_CTRL       12'h2c3
`define ADDR_IRQ_STAT   12'h2c4
`define ADDR_IRQ_MASK   12'h2c5
`define ADDR_MIX_FIRST  12'h660
`define ADDR_MIX_LAST   12'h66f

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define CTRL_COMFORT_BIT 7
`define CTRL_ENABLE_BIT  6
`define CTRL_RATE_LSB    0
`define CTRL_RATE_W      4
`define SRC_W            9
`define VOL_W            8
`define STS_BIT          15
`define VOL_RESET        8'h80
`define VOL_SHIFT        7
`define IRQ_W            2
`define IRQ_UNDERCLK     0
`define IRQ_PATH_ON      1

// ****************************************************************
// Sources and timing
// ****************************************************************
`define SRC_SILENCE     9'h000
`define SRC_STAGE_OUT   9'h00c
`define SRC_BANK_BASE   9'h010
`define SRC_BANK_N      16
`define SRC_BANK_IDX_W  4
`define SAMPLE_W        24
`define PATHS           8
`define PATH_CYCLES     256
`define CLK_HZ_DEFAULT  125000000
`define PERIOD_W        20

`endif

// ==== hdl/mic_mute_pkg.sv ====
`include "mic_mute_defs.svh"
package mic_mute_pkg;
	typedef logic signed [`SAMPLE_W-1:0] sample_t;
	typedef sample_t [`SRC_BANK_N-1:0] src_bank_t;
	typedef sample_t [3:0] quad_sample_t;
	typedef logic [3:0][`VOL_W-1:0] quad_vol_t;
	typedef struct packed {
		logic                    comfort_select;
		logic                    stage_output_enable;
		logic [`CTRL_RATE_W-1:0] stage_rate_setting;
	} ctrl_t;
	typedef struct packed {
		logic [`SRC_W-1:0] input_source_select;
		logic [`VOL_W-1:0] volume;
	} path_cfg_t;
endpackage

// ==== hdl/sample_tick.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mic_mute_defs.svh"
module sample_tick (
	input  wire logic                 clock_i,
	input  wire logic                 rstn_i,
	input  wire logic [`PERIOD_W-1:0] period_i,
	output logic                      tick_o
);
	logic [`PERIOD_W-1:0] count_reg;

	// Counts clock cycles per sample; a new period is compared every cycle and applies at once, mid-sample
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			count_reg <= '0;
			tick_o    <= 1'b0;
		end else if (count_reg + `PERIOD_W'(1) >= period_i) begin
			count_reg <= '0;
			tick_o    <= 1'b1;
		end else begin
			count_reg <= count_reg + `PERIOD_W'(1);
			tick_o    <= 1'b0;
		end
	end
endmodule // sample_tick
`default_nettype wire

// ==== hdl/mix4.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mic_mute_defs.svh"
module mix4 (
	input  wire logic                      clock_i,
	input  wire logic                      rstn_i,
	input  wire logic                      tick_i,
	input  wire logic [3:0]                active_i,
	input  wire mic_mute_pkg::quad_sample_t samples_i,
	input  wire mic_mute_pkg::quad_vol_t    vols_i,
	output mic_mute_pkg::sample_t           mix_o
);
	localparam int ACC_W = `SAMPLE_W + `VOL_W + 3;

	// Clamps a wide sum into the sample range
	function automatic mic_mute_pkg::sample_t sat(input logic signed [ACC_W-1:0] v);
		logic signed [ACC_W-1:0] hi;
		logic signed [ACC_W-1:0] lo;
		hi = ACC_W'({1'b0, {(`SAMPLE_W-1){1'b1}}});
		lo = -hi - ACC_W'(1);
		if (v > hi) sat = mic_mute_pkg::sample_t'(hi);
		else if (v < lo) sat = mic_mute_pkg::sample_t'(lo);
		else sat = v[`SAMPLE_W-1:0];
	endfunction

	logic signed [ACC_W-1:0] acc;

	// Volume per path before the sum; inactive paths add nothing
	always_comb begin
		acc = '0;
		for (int i = 0; i < 4; i++) begin
			if (active_i[i]) begin
				acc = acc + ((ACC_W'(samples_i[i]) *
					ACC_W'($signed({1'b0, vols_i[i]}))) >>> `VOL_SHIFT);
			end
		end
	end

	// New mix once per sample
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mix_o <= '0;
		end else if (tick_i) begin
			mix_o <= sat(acc);
		end
	end
endmodule // mix4
`default_nettype wire

// ==== hdl/mic_mute_mixer_mux.sv ====
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "mic_mute_defs.svh"
module mic_mute_mixer_mux #(
	parameter int CLK_HZ = `CLK_HZ_DEFAULT
) (
	input  wire logic                      clock_i,
	input  wire logic                      rstn_i,
	input  wire logic [`ADDR_W-1:0]        addr_i,
	input  wire logic [`DATA_W-1:0]        wdata_i,
	input  wire logic                      wr_i,
	input  wire logic                      rd_i,
	output logic [`DATA_W-1:0]             rdata_o,
	input  wire mic_mute_pkg::src_bank_t   sources_i,
	output mic_mute_pkg::sample_t          stage_sample_o,
	output logic                           stage_tick_o,
	output logic [`SRC_W-1:0]              stage_src_code_o,
	output logic                           underclock_gpio_o,
	output logic                           irq_o
);
	// ****************************************************************
	// Helper functions
	// ****************************************************************

	// Sample rate in Hz for each stage rate setting code
	function automatic int rate_hz(input logic [`CTRL_RATE_W-1:0] code);
		case (code)
			4'h0: rate_hz = 8000;
			4'h1: rate_hz = 16000;
			4'h2: rate_hz = 32000;
			4'h3: rate_hz = 48000;
			4'h4: rate_hz = 96000;
			4'h5: rate_hz = 192000;
			4'h6: rate_hz = 11025;
			4'h7: rate_hz = 22050;
			4'h8: rate_hz = 44100;
			4'h9: rate_hz = 88200;
			4'ha: rate_hz = 176400;
			default: rate_hz = 48000;
		endcase
	endfunction

	// Clock cycles that fit in one sample period, rounded down
	function automatic logic [`PERIOD_W-1:0] period_of(
		input logic [`CTRL_RATE_W-1:0] code);
		int p;
		p = CLK_HZ / rate_hz(code);
		if (p < 1) p = 1;
		period_of = `PERIOD_W'(p);
	endfunction

	// Number of paths currently running
	function automatic int count_on(input logic [`PATHS-1:0] v);
		count_on = 0;
		for (int i = 0; i < `PATHS; i++) begin
			count_on = count_on + int'(v[i]);
		end
	endfunction

	// Maps a source code onto a sample; anything unknown is silence
	function automatic mic_mute_pkg::sample_t pick(
		input logic [`SRC_W-1:0] code,
		input mic_mute_pkg::src_bank_t bank);
		logic [`SRC_W-1:0] off;
		off = code - `SRC_BANK_BASE;
		if (code == `SRC_SILENCE) begin
			pick = '0;
		end else if (code == `SRC_STAGE_OUT) begin
			pick = '0; // Own output would loop back on itself
		end else if (code >= `SRC_BANK_BASE &&
				off < `SRC_W'(`SRC_BANK_N)) begin
			pick = bank[off[`SRC_BANK_IDX_W-1:0]];
		end else begin
			pick = '0;
		end
	endfunction

	// ****************************************************************
	// Registers
	// ****************************************************************
	mic_mute_pkg::ctrl_t     ctrl_reg;
	mic_mute_pkg::path_cfg_t cfg_reg [`PATHS];
	logic [`PATHS-1:0]       path_on_reg;
	logic [`IRQ_W-1:0]       irq_stat_reg;
	logic [`IRQ_W-1:0]       irq_mask_reg;
	logic                    comfort_live_reg;
	logic                    enable_live_reg;

	// Decoded access
	logic                    in_mix;
	logic [`ADDR_W-1:0]      mix_off;
	logic [2:0]              path_idx;
	logic                    is_vol;
	logic                    src_wr;
	logic [`SRC_W-1:0]       new_src;
	logic                    try_enable;
	logic                    budget_ok;
	logic                    refuse;
	logic                    grant;
	logic [`PERIOD_W-1:0]    period;
	logic                    tick;

	// Mixer registers: even word is source select, odd word is volume
	assign in_mix   = addr_i >= `ADDR_MIX_FIRST &&
	                  addr_i <= `ADDR_MIX_LAST;
	assign mix_off  = addr_i - `ADDR_MIX_FIRST;
	assign path_idx = mix_off[3:1];
	assign is_vol   = mix_off[0];
	assign src_wr   = wr_i && in_mix && !is_vol;
	assign new_src  = wdata_i[`SRC_W-1:0];

	// Enable attempt: a non-silent source written to an idle path
	assign try_enable = src_wr && new_src != `SRC_SILENCE &&
	                    !path_on_reg[path_idx];

	// Each running path costs a fixed 256 clock cycles of the sample period
	assign budget_ok = (count_on(path_on_reg) + 1) * `PATH_CYCLES <=
	                   int'(period);
	assign refuse    = try_enable && !budget_ok;
	assign grant     = try_enable && budget_ok;

	// ****************************************************************
	// Sample timing
	// ****************************************************************
	assign period = period_of(ctrl_reg.stage_rate_setting);

	sample_tick u_tick (
		.clock_i  (clock_i),
		.rstn_i   (rstn_i),
		.period_i (period),
		.tick_o   (tick)
	);

	// ****************************************************************
	// Software registers
	// ****************************************************************

	// Stage control word
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl_reg <= '0;
		end else if (wr_i && addr_i == `ADDR_CTRL) begin
			ctrl_reg.comfort_select      <= wdata_i[`CTRL_COMFORT_BIT];
			ctrl_reg.stage_output_enable <= wdata_i[`CTRL_ENABLE_BIT];
			ctrl_reg.stage_rate_setting  <=
				wdata_i[`CTRL_RATE_LSB +: `CTRL_RATE_W];
		end
	end

	// Path source and volume; a refused source is not stored
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < `PATHS; i++) begin
				cfg_reg[i].input_source_select <= `SRC_SILENCE;
				cfg_reg[i].volume              <= `VOL_RESET;
			end
		end else if (wr_i && in_mix) begin
			if (is_vol) begin
				cfg_reg[path_idx].volume <= wdata_i[`VOL_W-1:0];
			end else if (!refuse) begin
				cfg_reg[path_idx].input_source_select <= new_src;
			end
		end
	end

	// Path run state; only the addressed path can change
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			path_on_reg <= '0;
		end else if (src_wr) begin
			if (new_src == `SRC_SILENCE) begin
				path_on_reg[path_idx] <= 1'b0;
			end else if (grant) begin
				path_on_reg[path_idx] <= 1'b1;
			end
			// Refused: every other path keeps running
		end
	end

	// Sticky events, write one to clear, a new event wins over clear
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_stat_reg <= '0;
		end else begin
			for (int i = 0; i < `IRQ_W; i++) begin
				if (wr_i && addr_i == `ADDR_IRQ_STAT && wdata_i[i]) begin
					irq_stat_reg[i] <= 1'b0;
				end
			end
			if (refuse) begin
				irq_stat_reg[`IRQ_UNDERCLK] <= 1'b1;
			end
			if (grant) begin
				irq_stat_reg[`IRQ_PATH_ON] <= 1'b1;
			end
		end
	end

	// Interrupt mask
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_mask_reg <= '0;
		end else if (wr_i && addr_i == `ADDR_IRQ_MASK) begin
			irq_mask_reg <= wdata_i[`IRQ_W-1:0];
		end
	end

	// Interrupt line, high while an unmasked event is pending
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// Pin copy of the under-clock flag
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			underclock_gpio_o <= 1'b0;
		end else begin
			underclock_gpio_o <= irq_stat_reg[`IRQ_UNDERCLK];
		end
	end

	// ****************************************************************
	// Read port
	// ****************************************************************

	// Read data stands in the cycle after the strobe only
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= '0;
		end else if (!rd_i) begin
			rdata_o <= '0;
		end else if (addr_i == `ADDR_CTRL) begin
			rdata_o <= '0;
			rdata_o[`CTRL_COMFORT_BIT] <= ctrl_reg.comfort_select;
			rdata_o[`CTRL_ENABLE_BIT]  <= ctrl_reg.stage_output_enable;
			rdata_o[`CTRL_RATE_LSB +: `CTRL_RATE_W] <=
				ctrl_reg.stage_rate_setting;
		end else if (addr_i == `ADDR_IRQ_STAT) begin
			rdata_o <= `DATA_W'(irq_stat_reg);
		end else if (addr_i == `ADDR_IRQ_MASK) begin
			rdata_o <= `DATA_W'(irq_mask_reg);
		end else if (in_mix && is_vol) begin
			rdata_o <= `DATA_W'(cfg_reg[path_idx].volume);
		end else if (in_mix) begin
			rdata_o <= `DATA_W'(cfg_reg[path_idx].input_source_select);
			rdata_o[`STS_BIT] <= path_on_reg[path_idx];
		end else begin
			rdata_o <= '0;
		end
	end

	// ****************************************************************
	// Mixers and multiplexer
	// ****************************************************************
	mic_mute_pkg::quad_sample_t voice_in;
	mic_mute_pkg::quad_sample_t noise_in;
	mic_mute_pkg::quad_vol_t    voice_vol;
	mic_mute_pkg::quad_vol_t    noise_vol;
	mic_mute_pkg::sample_t      voice_mix;
	mic_mute_pkg::sample_t      noise_mix;

	// Paths 0-3 feed the voice mixer, paths 4-7 the comfort noise mixer
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			voice_in[i]  = pick(cfg_reg[i].input_source_select, sources_i);
			noise_in[i]  = pick(cfg_reg[i+4].input_source_select, sources_i);
			voice_vol[i] = cfg_reg[i].volume;
			noise_vol[i] = cfg_reg[i+4].volume;
		end
	end

	mix4 u_voice_mixer (
		.clock_i   (clock_i),
		.rstn_i    (rstn_i),
		.tick_i    (tick),
		.active_i  (path_on_reg[3:0]),
		.samples_i (voice_in),
		.vols_i    (voice_vol),
		.mix_o     (voice_mix)
	);

	mix4 u_comfort_noise_mixer (
		.clock_i   (clock_i),
		.rstn_i    (rstn_i),
		.tick_i    (tick),
		.active_i  (path_on_reg[7:4]),
		.samples_i (noise_in),
		.vols_i    (noise_vol),
		.mix_o     (noise_mix)
	);

	// Select and enable are latched at a sample boundary
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			comfort_live_reg <= 1'b0;
			enable_live_reg  <= 1'b0;
		end else if (tick) begin
			comfort_live_reg <= ctrl_reg.comfort_select;
			enable_live_reg  <= ctrl_reg.stage_output_enable;
		end
	end

	// One mixer result, or zero while disabled, reaches the output at a tick, held in between
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stage_sample_o <= '0;
		end else if (tick && !enable_live_reg) begin
			stage_sample_o <= '0;
		end else if (tick && comfort_live_reg) begin
			stage_sample_o <= noise_mix;
		end else if (tick) begin
			stage_sample_o <= voice_mix;
		end
	end

	// Sample strobe for consumers at the stage rate
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stage_tick_o <= 1'b0;
		end else begin
			stage_tick_o <= tick;
		end
	end

	// Code by which other functions select this output
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stage_src_code_o <= `SRC_STAGE_OUT;
		end else begin
			stage_src_code_o <= `SRC_STAGE_OUT;
		end
	end
endmodule // mic_mute_mixer_mux
`default_nettype wire

// ==== sim/mic_mute_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mic_mute_defs.svh"
// ********
// Stage port checks
// ********
module mic_mute_sva (
	input wire logic                  clock_i,
	input wire logic                  rstn_i,
	input wire logic [`ADDR_W-1:0]    addr_i,
	input wire logic [`DATA_W-1:0]    wdata_i,
	input wire logic                  wr_i,
	input wire logic                  rd_i,
	input wire logic [`DATA_W-1:0]    rdata_o,
	input wire mic_mute_pkg::sample_t stage_sample_o,
	input wire logic                  stage_tick_o,
	input wire logic [`SRC_W-1:0]     stage_src_code_o,
	input wire logic                  underclock_gpio_o,
	input wire logic                  irq_o
);
	// Single clock domain for every check
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	// Stage ticks seen since the stage was switched off, saturating
	logic [2:0] off_ticks_reg;
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			off_ticks_reg <= 3'h0;
		end else if (wr_i && addr_i == `ADDR_CTRL) begin
			off_ticks_reg <= wdata_i[`CTRL_ENABLE_BIT] ? 3'h0 : 3'h1;
		end else if (stage_tick_o && off_ticks_reg != 3'h0
				&& off_ticks_reg != 3'h4) begin
			off_ticks_reg <= off_ticks_reg + 3'h1;
		end
	end
	chk_src_code_const:
		assert property (stage_src_code_o == `SRC_STAGE_OUT)
		else $error("stage source code wrong");
	chk_rdata_idle_zero:
		assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
		else $error("read data not zero outside read");
	chk_unmapped_read:
		assert property (rd_i && addr_i == 12'h670 |=> rdata_o == 16'h0000)
		else $error("unmapped read not zero");
	chk_tick_spacing:
		assert property (stage_tick_o |=> !stage_tick_o [*8])
		else $error("sample ticks too close");
	chk_sample_hold:
		assert property (!stage_tick_o |-> $stable(stage_sample_o))
		else $error("sample changed off a boundary");
	chk_gpio_after_write:
		assert property ($rose(underclock_gpio_o) |-> $past(wr_i, 2))
		else $error("error pin rose without a write");
	chk_irq_after_write:
		assert property ($rose(irq_o) |-> $past(wr_i, 2))
		else $error("interrupt rose without a write");
	chk_mask_off_irq:
		assert property (wr_i && addr_i == `ADDR_IRQ_MASK
			&& wdata_i[1:0] == 2'b00 |-> ##2 !irq_o)
		else $error("interrupt high with mask clear");
	chk_disabled_zero:
		assert property (off_ticks_reg == 3'h4 |-> stage_sample_o == '0)
		else $error("disabled stage not silent");
endmodule // mic_mute_sva
bind mic_mute_mixer_mux mic_mute_sva i_sva (
	.clock_i(clock_i),
	.rstn_i(rstn_i),
	.addr_i(addr_i),
	.wdata_i(wdata_i),
	.wr_i(wr_i),
	.rd_i(rd_i),
	.rdata_o(rdata_o),
	.stage_sample_o(stage_sample_o),
	.stage_tick_o(stage_tick_o),
	.stage_src_code_o(stage_src_code_o),
	.underclock_gpio_o(underclock_gpio_o),
	.irq_o(irq_o)
);
`default_nettype wire

// ==== sim/far_side_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mic_mute_defs.svh"
// ********
// Upstream core sources
// ********
module far_side_model (
	input  wire logic                  clock_i,
	input  wire logic                  rstn_i,
	input  wire logic                  tick_i,
	input  wire mic_mute_pkg::sample_t base_i,
	output var mic_mute_pkg::src_bank_t sources_o
);
	mic_mute_pkg::sample_t cur_reg;
	// New upstream sample once per stage period
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cur_reg <= '0;
		end else if (tick_i) begin
			cur_reg <= base_i;
		end
	end
	// Source k carries the sample plus k
	always_comb begin
		for (int k = 0; k < `SRC_BANK_N; k++) begin
			sources_o[k] = cur_reg + mic_mute_pkg::sample_t'(k);
		end
	end
endmodule // far_side_model
`default_nettype wire

// ==== sim/test_mic_mute_mixer_mux.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mic_mute_defs.svh"
// ********
// Bench for the mic mute stage
// ********
module test_mic_mute_mixer_mux;
	logic                    clock_i = 1'b0;
	logic                    rstn_i = 1'b0;
	logic [`ADDR_W-1:0]      addr_i = '0;
	logic [`DATA_W-1:0]      wdata_i = '0;
	logic                    wr_i = 1'b0;
	logic                    rd_i = 1'b0;
	logic [`DATA_W-1:0]      rdata_o;
	mic_mute_pkg::src_bank_t sources_i;
	mic_mute_pkg::sample_t   stage_sample_o;
	mic_mute_pkg::sample_t   base = '0;
	logic                    stage_tick_o;
	logic [`SRC_W-1:0]       stage_src_code_o;
	logic                    underclock_gpio_o;
	logic                    irq_o;
	logic [15:0]             rnd = 16'h0015;
	logic [7:0]              vol;
	logic [`DATA_W-1:0]      d;
	int                      num_errors = 0;
	int                      cmp_count = 0;

	// 125 MHz clock
	always #4 clock_i = ~clock_i;

	mic_mute_mixer_mux i_dut (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.rdata_o(rdata_o),
		.sources_i(sources_i),
		.stage_sample_o(stage_sample_o),
		.stage_tick_o(stage_tick_o),
		.stage_src_code_o(stage_src_code_o),
		.underclock_gpio_o(underclock_gpio_o),
		.irq_o(irq_o)
	);

	far_side_model i_far (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.tick_i(stage_tick_o),
		.base_i(base),
		.sources_o(sources_i)
	);

	// Pseudo random step
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Sample times volume with unity at 80h
	function automatic mic_mute_pkg::sample_t scaled(
		input mic_mute_pkg::sample_t b, input logic [7:0] v);
		longint p;
		p = longint'(b) * longint'(v);
		return mic_mute_pkg::sample_t'(p >>> 7);
	endfunction

	// Compare and count
	task automatic chk(input string n, input logic [23:0] e,
		input logic [23:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			num_errors++;
		end
	endtask

	// One write cycle
	task automatic wr(input logic [11:0] a, input logic [15:0] v);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask

	// One read cycle, data taken the cycle after
	task automatic rc(input logic [11:0] a, input logic [15:0] e);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
		chk($sformatf("reg %h", a), 24'(e), 24'(d));
	endtask

	// Wait for n stage samples
	task automatic ticks(input int n);
		int k;
		repeat (n) begin
			k = 0;
			do begin
				@(posedge clock_i);
				k++;
			end while (stage_tick_o !== 1'b1 && k < 20000);
		end
		#1;
	endtask

	// Verdict and end of run
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (10) @(posedge clock_i);
		rstn_i <= 1'b1;
		rc(`ADDR_CTRL, 16'h0000);
		rc(`ADDR_MIX_FIRST, 16'h0000);
		rc(`ADDR_MIX_LAST, 16'h0080);
		rc(`ADDR_IRQ_STAT, 16'h0000);
		rc(12'h670, 16'h0000);
		chk("src code", 24'h00000c, 24'(stage_src_code_o));
		wr(`ADDR_CTRL, 16'h0045);
		wr(`ADDR_IRQ_MASK, 16'h0001);
		wr(`ADDR_MIX_FIRST, 16'h0010);
		wr(12'h668, 16'h0011);
		wr(12'h662, 16'h0012);
		rc(12'h662, 16'h0000);
		rc(`ADDR_MIX_FIRST, 16'h8010);
		rc(12'h668, 16'h8011);
		rc(`ADDR_IRQ_STAT, 16'h0003);
		chk("irq", 24'h1, 24'(irq_o));
		chk("gpio", 24'h1, 24'(underclock_gpio_o));
		wr(`ADDR_IRQ_STAT, 16'h0001);
		rc(`ADDR_IRQ_STAT, 16'h0002);
		chk("irq masked", 24'h0, 24'(irq_o));
		chk("gpio clear", 24'h0, 24'(underclock_gpio_o));
		wr(`ADDR_IRQ_MASK, 16'h0002);
		rc(`ADDR_IRQ_MASK, 16'h0002);
		chk("irq path", 24'h1, 24'(irq_o));
		wr(`ADDR_IRQ_MASK, 16'h0000);
		// Random samples on the voice path; volumes 80h, then FFh, then random
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			base <= mic_mute_pkg::sample_t'(signed'(rnd));
			rnd = lfsr(rnd);
			vol = (i == 0) ? 8'h80 : (i == 1) ? 8'hff : rnd[7:0];
			wr(`ADDR_MIX_FIRST + 12'h1, {8'h00, vol});
			ticks(3);
			chk("voice", scaled(base, vol), stage_sample_o);
		end
		wr(`ADDR_CTRL, 16'h00c5);
		ticks(3);
		chk("comfort", base + 24'sd1, stage_sample_o);
		wr(`ADDR_CTRL, 16'h0085);
		ticks(3);
		chk("disabled", 24'h0, stage_sample_o);
		wr(`ADDR_CTRL, 16'h0045);
		ticks(3);
		chk("voice back", scaled(base, vol), stage_sample_o);
		wr(`ADDR_MIX_FIRST, 16'h0000);
		ticks(3);
		chk("silence", 24'h0, stage_sample_o);
		rc(`ADDR_MIX_FIRST, 16'h0000);
		wr(12'h662, 16'h0012);
		rc(12'h662, 16'h8012);
		ticks(3);
		chk("second path", base + 24'sd2, stage_sample_o);
		// Slowest rate leaves room for a third path
		wr(`ADDR_CTRL, 16'h0040);
		wr(12'h664, 16'h0013);
		rc(12'h664, 16'h8013);
		tally_and_finish();
	end

	// Watchdog against a hang
	initial begin
		repeat (90000) @(posedge clock_i);
		num_errors++;
		tally_and_finish();
	end
endmodule // test_mic_mute_mixer_mux
`default_nettype wire
